// >>> i2c_target_interface.sv
// Purpose: Two-wire bus target with address match, read and write
// Assumes: Bus pins are asynchronous; mclk far faster than the bus clock
// Notes:   Lines are open-drain: outputs are constant low, enables drive
`timescale 1ns/10ps
`include "i2c_target_cfg.svh"
module i2c_target_interface #(
  parameter int RX_DEPTH = `RX_BUF_DEPTH
) (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      scl_i,
  output logic                           scl_o,
  output logic                           scl_oe,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  input  wire logic [`ADDR_BITS-1:0]     own_addr,
  output logic                           busy,
  output logic                           rd_dir,
  output i2c_target_pkg::byte_t          rx_data,
  output logic                           rx_valid,
  input  wire logic                      rx_ready,
  input  wire i2c_target_pkg::byte_t     tx_data,
  input  wire logic                      tx_valid,
  output logic                           tx_ready
);
  import i2c_target_pkg::*;

  logic              scl_m, scl_s, scl_d;
  logic              sda_m, sda_s, sda_d;
  logic              scl_rise, scl_fall, start_det, stop_det;
  tgt_state_e        state, next_state;
  logic [`CNT_W-1:0] cnt, next_cnt;
  byte_t             shift, next_shift;
  logic              next_sda_oe, next_scl_oe, next_busy, next_rd_dir;
  logic              nack, next_nack;
  logic              push, buf_ready;

  // Open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // Two flops per pin, third stage only for edge finding
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_shift  = shift;
    next_sda_oe = sda_oe;
    next_scl_oe = scl_oe;
    next_busy   = busy;
    next_rd_dir = rd_dir;
    next_nack   = nack;
    push        = 1'b0;
    tx_ready    = 1'b0;
    if (start_det) begin
      // Repeated start restarts from any state
      next_state  = ST_ADDR;
      next_cnt    = '0;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_busy   = 1'b1;
    end else if (stop_det) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_busy   = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
          next_scl_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_cnt   = cnt + 1'b1;
          end else if (scl_fall && cnt == `LAST_RX_BIT) begin
            if (shift[7:1] == own_addr) begin
              next_rd_dir = shift[0];
              next_sda_oe = 1'b1;
              next_state  = ST_ACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt    = '0;
            next_state  = rd_dir ? ST_RD_WAIT : ST_WR_DATA;
          end
        end
        ST_WR_DATA: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_cnt   = cnt + 1'b1;
          end else if (scl_fall && cnt == `LAST_RX_BIT) begin
            next_state = ST_WR_HOLD;
          end
        end
        ST_WR_HOLD: begin
          // Full buffer stretches the clock instead of dropping a byte
          if (buf_ready) begin
            push        = 1'b1;
            next_sda_oe = 1'b1;
            next_scl_oe = 1'b0;
            next_state  = ST_ACK;
          end else begin
            next_scl_oe = 1'b1;
          end
        end
        ST_RD_WAIT: begin
          if (tx_valid) begin
            tx_ready    = 1'b1;
            // Back-to-back reads arrive here from the ack, not via ST_ACK
            next_cnt    = '0;
            next_shift  = tx_data;
            next_sda_oe = ~tx_data[7];
            next_scl_oe = 1'b0;
            next_state  = ST_RD_DATA;
          end else begin
            next_scl_oe = 1'b1;
          end
        end
        ST_RD_DATA: begin
          if (scl_fall) begin
            next_cnt = cnt + 1'b1;
            if (cnt == `LAST_TX_BIT) begin
              next_sda_oe = 1'b0;
              next_state  = ST_RD_ACK;
            end else begin
              next_shift  = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_nack = sda_s;
          end else if (scl_fall) begin
            next_state = nack ? ST_IDLE : ST_RD_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state  <= ST_IDLE;
      cnt    <= '0;
      shift  <= 8'h00;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      busy   <= 1'b0;
      rd_dir <= 1'b0;
      nack   <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      shift  <= next_shift;
      sda_oe <= next_sda_oe;
      scl_oe <= next_scl_oe;
      busy   <= next_busy;
      rd_dir <= next_rd_dir;
      nack   <= next_nack;
    end
  end

  i2c_rx_buffer #(
    .WIDTH (`BYTE_BITS),
    .DEPTH (RX_DEPTH)
  ) u_rx_buffer (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (shift),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_addr_end;
    state == ST_ADDR && !start_det && !stop_det && scl_fall && cnt == `LAST_RX_BIT;
  endsequence

  property p_start_busy;
    start_det |=> busy && state == ST_ADDR && cnt == '0;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not seen");

  property p_stop_idle;
    stop_det && !start_det |=> !busy && state == ST_IDLE && !sda_oe && !scl_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");

  property p_addr_ack;
    s_addr_end ##0 (shift[7:1] == own_addr) |=> sda_oe && state == ST_ACK
      && rd_dir == $past(shift[0]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_foreign_quiet;
    s_addr_end ##0 (shift[7:1] != own_addr) |=> !sda_oe && !scl_oe && state == ST_IDLE;
  endproperty
  a_foreign_quiet: assert property (p_foreign_quiet) else $error("foreign addr");

  property p_msb_first;
    state == ST_ADDR && scl_rise && !start_det && !stop_det
      |=> shift == {$past(shift[6:0]), $past(sda_s)} && cnt == $past(cnt) + 1'b1;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("address shift order");

  property p_stable_high;
    scl_s && scl_d && !start_det && !stop_det && state != ST_WR_HOLD
      && state != ST_RD_WAIT |=> $stable(sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved, clock high");

  property p_write_ack;
    state == ST_WR_HOLD && buf_ready && !start_det && !stop_det
      |=> sda_oe && !scl_oe && state == ST_ACK;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write byte not acked");

  property p_stretch;
    scl_oe |-> state == ST_WR_HOLD || state == ST_RD_WAIT;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock held outside wait");

  property p_read_release;
    state == ST_RD_DATA && scl_fall && cnt == `LAST_TX_BIT && !start_det && !stop_det
      |=> !sda_oe && state == ST_RD_ACK ##1 !sda_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("ack cycle not freed");

  property p_nack_end;
    state == ST_RD_ACK && nack && scl_fall && !start_det && !stop_det
      |=> state == ST_IDLE && !sda_oe;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("nack did not end read");

  property p_read_load;
    state == ST_RD_WAIT && tx_valid && !start_det && !stop_det
      |=> state == ST_RD_DATA && cnt == '0 && sda_oe == !$past(tx_data[7]);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not loaded");
endmodule : i2c_target_interface

// >>> i2c_target_cfg.svh
// Purpose: Constants for the two-wire target interface
// Assumes: Bit counts follow the bus byte framing
// Notes:   Included by its bare name
`ifndef I2C_TARGET_CFG_SVH
`define I2C_TARGET_CFG_SVH
`define ADDR_BITS      7
`define BYTE_BITS      8
`define CNT_W          4
`define LAST_RX_BIT    4'h8
`define LAST_TX_BIT    4'h7
`define RX_BUF_DEPTH   2
`endif

// >>> i2c_target_pkg.sv
// Purpose: Types for the two-wire target interface
// Assumes: Nothing beyond the constants header
// Notes:   All eight state codes are legal
package i2c_target_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ACK     = 3'b010,
    ST_WR_DATA = 3'b011,
    ST_WR_HOLD = 3'b100,
    ST_RD_WAIT = 3'b101,
    ST_RD_DATA = 3'b110,
    ST_RD_ACK  = 3'b111
  } tgt_state_e;
  typedef logic [7:0] byte_t;
endpackage : i2c_target_pkg

// >>> i2c_rx_buffer.sv
// Purpose: Small FIFO between received bytes and the user
// Assumes: Same clock on both sides
// Notes:   Full and empty are exact; out_data comes from flops
`timescale 1ns/10ps
module i2c_rx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; valid gates it
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : i2c_rx_buffer

// >>> i2c_host_model.sv
// Purpose: Two-wire bus host model driving the target under test
// Assumes: Bench resolves both lines with pull-ups
// Notes:   Honours clock stretching with a bounded wait
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic mclk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  int stretch;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stretch = 0;
  end
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask : half
  // Bounded, so a stuck target cannot hang the host
  task automatic clk_hi();
    int n;
    n = 0;
    scl_oe = 1'b0;
    @(negedge mclk);
    while (scl !== 1'b1 && n < 5000) begin
      n++;
      stretch++;
      @(negedge mclk);
    end
    half();
  endtask : clk_hi
  task automatic clk_lo();
    scl_oe = 1'b1;
    half();
  endtask : clk_lo
  task automatic start();
    sda_oe = 1'b0;
    half();
    clk_hi();
    sda_oe = 1'b1;
    half();
    clk_lo();
  endtask : start
  task automatic stop();
    sda_oe = 1'b1;
    half();
    clk_hi();
    sda_oe = 1'b0;
    half();
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~b[i];
      half();
      clk_hi();
      clk_lo();
    end
    sda_oe = 1'b0;
    half();
    clk_hi();
    ack = ~sda;
    clk_lo();
  endtask : put_byte
  task automatic get_byte(output logic [7:0] d, input logic ack);
    sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      half();
      clk_hi();
      d[i] = sda;
      clk_lo();
    end
    sda_oe = ack;
    half();
    clk_hi();
    clk_lo();
    sda_oe = 1'b0;
  endtask : get_byte
endmodule : i2c_host_model

// >>> i2c_target_interface_tb_top.sv
// Purpose: Self-checking bench for the two-wire target
// Assumes: Host model on the bus, bench on the user side
// Notes:   Expected write bytes queued, monitor pops on acceptance
`timescale 1ns/10ps
module i2c_target_interface_tb_top;
  import i2c_target_pkg::*;
  logic       mclk = 1'b0;
  logic       resetn, rx_ready, tx_valid, stall, tx_en, ak;
  logic       scl_o, sda_o, scl_oe, sda_oe, h_scl, h_sda;
  logic       busy, rd_dir, rx_valid, tx_ready;
  logic [6:0] own;
  byte_t      rx_data, tx_data, b;
  byte_t      exp_q[$], tx_q[$], rd_q[$];
  int         err_count, total_checks, cyc, s0;
  wire        scl = !(scl_oe | h_scl);
  wire        sda = !(sda_oe | h_sda);
  i2c_target_interface uut (.mclk(mclk), .resetn(resetn), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .own_addr(own),
    .busy(busy), .rd_dir(rd_dir), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  i2c_host_model host (.mclk(mclk), .scl(scl), .sda(sda), .scl_oe(h_scl), .sda_oe(h_sda));
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  // Random receiver stalls exercise the buffer
  always @(negedge mclk) begin
    rx_ready <= !stall && ($urandom_range(0, 1) == 1);
    tx_valid <= tx_en && (tx_q.size() > 0);
    tx_data <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
  end
  always @(posedge mclk) begin
    if (tx_ready === 1'b1 && tx_q.size() > 0) void'(tx_q.pop_front());
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected rx byte");
      else chk(rx_data === exp_q.pop_front(), "rx data");
    end
  end
  initial begin
    {resetn, stall, tx_en} = 3'h0;
    {err_count, total_checks, cyc} = 0;
    void'($urandom(32'hEB5E));
    own = 7'($urandom_range(8, 119));
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    stall = 1'b1;
    host.start();
    chk(busy === 1'b1, "busy after start");
    host.put_byte({own, 1'b0}, ak);
    chk(ak === 1'b1, "write address ack");
    chk(rd_dir === 1'b0, "write direction");
    s0 = host.stretch;
    fork
      begin
        repeat (1200) @(negedge mclk);
        stall = 1'b0;
      end
    join_none
    for (int i = 0; i < 4; i++) begin
      b = byte_t'($urandom);
      exp_q.push_back(b);
      host.put_byte(b, ak);
      chk(ak === 1'b1, "data ack");
    end
    chk(host.stretch > s0, "stretch while buffer full");
    host.stop();
    repeat (8) @(negedge mclk);
    chk(busy === 1'b0, "idle after stop");
    $display("write test done");
    host.start();
    host.put_byte({own ^ 7'h01, 1'b0}, ak);
    chk(ak === 1'b0, "foreign address nack");
    host.put_byte(8'h00, ak);
    chk(ak === 1'b0, "foreign data ignored");
    host.stop();
    $display("foreign test done");
    repeat (2) begin
      b = byte_t'($urandom);
      tx_q.push_back(b);
      rd_q.push_back(b);
    end
    host.start();
    host.put_byte({own, 1'b1}, ak);
    chk(ak === 1'b1, "read address ack");
    chk(rd_dir === 1'b1, "read direction");
    s0 = host.stretch;
    fork
      begin
        repeat (300) @(negedge mclk);
        tx_en = 1'b1;
      end
    join_none
    host.get_byte(b, 1'b1);
    chk(b === rd_q.pop_front(), "read byte one");
    chk(host.stretch > s0, "stretch until tx data");
    host.get_byte(b, 1'b0);
    chk(b === rd_q.pop_front(), "read byte two");
    s0 = host.stretch;
    host.get_byte(b, 1'b0);
    chk(b === 8'hFF && host.stretch == s0, "silent after nack");
    host.stop();
    chk(scl_o === 1'b0 && sda_o === 1'b0, "open drain outputs");
    $display("read test done");
    repeat (50) @(negedge mclk);
    chk(exp_q.size() == 0, "all rx bytes delivered");
    test_done();
  end
endmodule : i2c_target_interface_tb_top
